// [smon_monitor.v]
`timescale 1ns/1ps
`include "smon_defs.vh"
module smon_monitor (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // register port from the serial interface
  input  wire [5:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // output update cycle and sample data, 11 channels of 16 bits, channel 1 in low bits
  input  wire         upd,
  input  wire [175:0] raw_data,
  input  wire [175:0] filt_data,
  // error conditions, same clock
  input  wire [5:0]  diag_fail,
  input  wire        selftest_err,
  input  wire        overrange,
  input  wire        serial_fail,
  input  wire        ctrl_upd_fail,
  input  wire        supply_high,
  input  wire        supply_low,
  // other claimants of the auxiliary lines
  input  wire        dready_en,
  input  wire        dready_line,
  input  wire        dready_level,
  input  wire [1:0]  gpio_oe,
  input  wire [1:0]  gpio_out,
  // auxiliary lines
  output reg  [1:0]  aux_out,
  output reg  [1:0]  aux_oe,
  output reg         alarm1_active,
  output reg         alarm2_active
);

  reg [15:0] alarm1_threshold;
  reg [15:0] alarm2_threshold;
  reg [15:0] alarm1_sample_count;
  reg [15:0] alarm2_sample_count;
  reg [15:0] alarm_configuration;
  reg [15:0] error_flags;

  // per-channel rate-of-change state
  reg [15:0] prev [0:1];
  reg        prev_ok [0:1];
  reg [23:0] acc [0:1];
  reg [7:0]  cnt [0:1];
  reg        alm [0:1];

  function [15:0] pick;
    input [3:0]   src;
    input [175:0] bus;
    begin
      if (src == `SMON_SRC_NONE || src > `SMON_SRC_LAST)
        pick = 16'h0000;
      else
        pick = bus[(src - 4'h1) * 16 +: 16];
    end
  endfunction

  // sign extension of a 14-bit sample or magnitude
  function [23:0] ext14;
    input [15:0] v;
    begin
      ext14 = {{10{v[13]}}, v[13:0]};
    end
  endfunction

  // 14-bit two's complement level compared with signed threshold magnitude
  function hit;
    input [15:0] thr;
    input [23:0] val;
    reg signed [23:0] m;
    begin
      m = ext14(thr);
      if (thr[`SMON_THR_GT])
        hit = ($signed(val) > m);
      else
        hit = ($signed(val) < m);
    end
  endfunction

  // a programmed count of zero averages one delta
  function [7:0] ndelta;
    input [7:0] n;
    begin
      if (n == 8'h00)
        ndelta = 8'h01;
      else
        ndelta = n;
    end
  endfunction

  // signed mean of the summed deltas
  function [23:0] mean;
    input [23:0] s;
    input [7:0]  n;
    begin
      mean = $signed(s) / $signed({16'h0000, n});
    end
  endfunction

  wire [175:0] src_bus = alarm_configuration[`SMON_CFG_FILT] ? filt_data : raw_data;
  wire [3:0]  src1 = alarm_configuration[`SMON_CFG_SRC1_HI -: 4];
  wire [3:0]  src2 = alarm_configuration[`SMON_CFG_SRC2_HI -: 4];
  wire [15:0] smp1 = pick(src1, src_bus);
  wire [15:0] smp2 = pick(src2, src_bus);

  wire [15:0] smp [0:1];
  wire [3:0]  srcs [0:1];
  wire        rate_of_change [0:1];
  wire [15:0] thr [0:1];
  wire [7:0]  nds [0:1];
  assign smp[0]  = smp1;
  assign smp[1]  = smp2;
  assign srcs[0] = src1;
  assign srcs[1] = src2;
  assign rate_of_change[0]  = alarm_configuration[`SMON_CFG_ROC1];
  assign rate_of_change[1]  = alarm_configuration[`SMON_CFG_ROC2];
  assign thr[0]  = alarm1_threshold;
  assign thr[1]  = alarm2_threshold;
  assign nds[0]  = alarm1_sample_count[7:0];
  assign nds[1]  = alarm2_sample_count[7:0];

  // per-channel delta sum, divisor and mean
  wire [23:0] sum [0:1];
  wire [7:0]  div [0:1];
  wire [23:0] avg [0:1];
  wire        lvl_hit [0:1];
  wire        roc_hit [0:1];
  assign sum[0]     = acc[0] + ext14(smp[0]) - ext14(prev[0]);
  assign sum[1]     = acc[1] + ext14(smp[1]) - ext14(prev[1]);
  assign div[0]     = ndelta(nds[0]);
  assign div[1]     = ndelta(nds[1]);
  assign avg[0]     = mean(sum[0], div[0]);
  assign avg[1]     = mean(sum[1], div[1]);
  assign lvl_hit[0] = hit(thr[0], ext14(smp[0]));
  assign lvl_hit[1] = hit(thr[1], ext14(smp[1]));
  assign roc_hit[0] = hit(thr[0], avg[0]);
  assign roc_hit[1] = hit(thr[1], avg[1]);

  reg [15:0] next_prev    [0:1];
  reg        next_prev_ok [0:1];
  reg [23:0] next_acc     [0:1];
  reg [7:0]  next_cnt     [0:1];
  reg        next_alm     [0:1];
  integer    i;
  integer    c;

  always @* begin
    for (i = 0; i < 2; i = i + 1) begin
      next_prev[i]    = prev[i];
      next_prev_ok[i] = prev_ok[i];
      next_acc[i]     = acc[i];
      next_cnt[i]     = cnt[i];
      next_alm[i]     = alm[i];
      if (upd) begin
        next_prev[i] = smp[i];
        if (srcs[i] == `SMON_SRC_NONE) begin
          next_alm[i]     = 1'b0;
          next_prev_ok[i] = 1'b0;
          next_acc[i]     = 24'h000000;
          next_cnt[i]     = 8'h00;
        end else if (!rate_of_change[i]) begin
          // static compare; rate history restarts on a later switch
          next_alm[i]     = lvl_hit[i];
          next_prev_ok[i] = 1'b0;
          next_acc[i]     = 24'h000000;
          next_cnt[i]     = 8'h00;
        end else if (!prev_ok[i]) begin
          next_prev_ok[i] = 1'b1;
        end else if (cnt[i] + 8'h01 >= div[i]) begin
          next_alm[i] = roc_hit[i];
          next_acc[i] = 24'h000000;
          next_cnt[i] = 8'h00;
        end else begin
          next_acc[i] = sum[i];
          next_cnt[i] = cnt[i] + 8'h01;
        end
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (c = 0; c < 2; c = c + 1) begin
        prev[c]    <= 16'h0000;
        prev_ok[c] <= 1'b0;
        acc[c]     <= 24'h000000;
        cnt[c]     <= 8'h00;
        alm[c]     <= 1'b0;
      end
    end else begin
      for (c = 0; c < 2; c = c + 1) begin
        prev[c]    <= next_prev[c];
        prev_ok[c] <= next_prev_ok[c];
        acc[c]     <= next_acc[c];
        cnt[c]     <= next_cnt[c];
        alm[c]     <= next_alm[c];
      end
    end
  end

  // conditions mapped onto the flag layout
  wire [15:0] cond;
  assign cond[15:`SMON_FLG_DIAG_LO] = diag_fail;
  assign cond[`SMON_FLG_ALM2]       = alm[1];
  assign cond[`SMON_FLG_ALM1]       = alm[0];
  assign cond[7:6]                  = 2'b00;
  assign cond[`SMON_FLG_SELFTEST]   = selftest_err;
  assign cond[`SMON_FLG_OVR]        = overrange;
  assign cond[`SMON_FLG_SERIAL]     = serial_fail;
  assign cond[`SMON_FLG_CTRLUPD]    = ctrl_upd_fail;
  assign cond[`SMON_FLG_SUP_HI]     = supply_high;
  assign cond[`SMON_FLG_SUP_LO]     = supply_low;
  wire [15:0] auto_mask = `SMON_AUTO_MASK;
  wire        rd_flags  = reg_rd && (reg_addr == `SMON_ADDR_FLAGS);
  reg  [15:0] next_error_flags;

  always @* begin
    next_error_flags = error_flags;
    if (rd_flags)
      next_error_flags = 16'h0000;
    if (upd)
      next_error_flags = next_error_flags & ~auto_mask;
    // persisting errors set again at update; set wins over clear
    if (upd)
      next_error_flags = next_error_flags | cond;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error_flags <= `SMON_RST_16;
    end else begin
      error_flags <= next_error_flags;
    end
  end

  // register writes; unused bits masked
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm1_threshold    <= `SMON_RST_16;
      alarm2_threshold    <= `SMON_RST_16;
      alarm1_sample_count <= `SMON_RST_16;
      alarm2_sample_count <= `SMON_RST_16;
      alarm_configuration <= `SMON_RST_16;
    end else if (reg_wr) begin
      case (reg_addr)
        `SMON_ADDR_THR1: alarm1_threshold    <= reg_wdata & `SMON_THR_MASK;
        `SMON_ADDR_THR2: alarm2_threshold    <= reg_wdata & `SMON_THR_MASK;
        `SMON_ADDR_CNT1: alarm1_sample_count <= reg_wdata & `SMON_CNT_MASK;
        `SMON_ADDR_CNT2: alarm2_sample_count <= reg_wdata & `SMON_CNT_MASK;
        `SMON_ADDR_CFG:  alarm_configuration <= reg_wdata & `SMON_CFG_MASK;
        default: ;
      endcase
    end
  end

  // read data registered, returns contents before the clear
  reg [15:0] next_reg_rdata;

  always @* begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `SMON_ADDR_THR1:  next_reg_rdata = alarm1_threshold;
        `SMON_ADDR_THR2:  next_reg_rdata = alarm2_threshold;
        `SMON_ADDR_CNT1:  next_reg_rdata = alarm1_sample_count;
        `SMON_ADDR_CNT2:  next_reg_rdata = alarm2_sample_count;
        `SMON_ADDR_CFG:   next_reg_rdata = alarm_configuration;
        `SMON_ADDR_FLAGS: next_reg_rdata = error_flags;
        default:          next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `SMON_RST_16;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // auxiliary line drive
  wire       any_alm  = alm[0] | alm[1];
  wire       alm_en   = alarm_configuration[`SMON_CFG_OEN];
  wire       alm_lvl  = alarm_configuration[`SMON_CFG_POL] ? any_alm : ~any_alm;
  wire       alm_line = alarm_configuration[`SMON_CFG_LINE];
  reg  [1:0] next_aux_out;
  reg  [1:0] next_aux_oe;
  integer    k;

  always @* begin
    next_aux_oe  = 2'b00;
    next_aux_out = 2'b00;
    for (k = 0; k < 2; k = k + 1) begin
      // data-ready first, alarm second, general-purpose last
      if (dready_en && (dready_line == k[0])) begin
        next_aux_oe[k]  = 1'b1;
        next_aux_out[k] = dready_level;
      end else if (alm_en && (alm_line == k[0])) begin
        next_aux_oe[k]  = 1'b1;
        next_aux_out[k] = alm_lvl;
      end else begin
        next_aux_oe[k]  = gpio_oe[k];
        next_aux_out[k] = gpio_out[k];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_out       <= 2'b00;
      aux_oe        <= 2'b00;
      alarm1_active <= 1'b0;
      alarm2_active <= 1'b0;
    end else begin
      aux_out       <= next_aux_out;
      aux_oe        <= next_aux_oe;
      alarm1_active <= alm[0];
      alarm2_active <= alm[1];
    end
  end

endmodule // smon_monitor

// [smon_defs.vh]
`ifndef SMON_DEFS_VH
`define SMON_DEFS_VH
`define SMON_ADDR_THR1    6'h26
`define SMON_ADDR_THR2    6'h28
`define SMON_ADDR_CNT1    6'h2a
`define SMON_ADDR_CNT2    6'h2c
`define SMON_ADDR_CFG     6'h2e
`define SMON_ADDR_FLAGS   6'h3c
`define SMON_RST_16       16'h0000
`define SMON_THR_MASK     16'hbfff
`define SMON_CNT_MASK     16'h00ff
`define SMON_CFG_MASK     16'hffd7
`define SMON_AUTO_MASK    16'h0013
`define SMON_THR_GT       15
`define SMON_CFG_SRC2_HI  15
`define SMON_CFG_SRC1_HI  11
`define SMON_CFG_ROC2     7
`define SMON_CFG_ROC1     6
`define SMON_CFG_FILT     4
`define SMON_CFG_OEN      2
`define SMON_CFG_POL      1
`define SMON_CFG_LINE     0
`define SMON_FLG_DIAG_LO  10
`define SMON_FLG_ALM2     9
`define SMON_FLG_ALM1     8
`define SMON_FLG_SELFTEST 5
`define SMON_FLG_OVR      4
`define SMON_FLG_SERIAL   3
`define SMON_FLG_CTRLUPD  2
`define SMON_FLG_SUP_HI   1
`define SMON_FLG_SUP_LO   0
`define SMON_SRC_NONE     4'h0
`define SMON_SRC_LAST     4'hb
`endif

// [smon_host.sv]
`timescale 1ns/1ps
module smon_host (
  // clock and read data
  input  wire        clk,
  input  wire [15:0] reg_rdata,
  // request
  output reg  [5:0]  reg_addr,
  output reg         reg_wr,
  output reg  [15:0] reg_wdata,
  output reg         reg_rd
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 24'h000000;
  task wr(input [5:0] a, input [15:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  // read data is registered, so it is taken just after the strobe's edge
  task rd(input [5:0] a, output [15:0] v);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
endmodule // smon_host

// [smon_checker.sv]
`timescale 1ns/1ps
module smon_checker (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // register side
  input wire [5:0]  reg_addr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // update and conditions
  input wire        upd,
  input wire        selftest_err,
  input wire        supply_high,
  // auxiliary lines
  input wire        dready_en,
  input wire        dready_line,
  input wire        dready_level,
  input wire [1:0]  gpio_oe,
  input wire [1:0]  aux_out,
  input wire [1:0]  aux_oe,
  input wire        alarm1_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rf = reg_rd && reg_addr == 6'h3c;
  a_selftest_sticky: assert property (upd && selftest_err ##1 !rf ##1 rf |=> reg_rdata[5])
    else $error("self-test flag not kept");
  a_read_clears: assert property (rf && !upd ##1 !upd ##1 rf |=> reg_rdata == 16'h0000)
    else $error("flags not cleared by read");
  a_supply_set: assert property (upd && supply_high ##1 !upd && !rf ##1 rf |=> reg_rdata[1])
    else $error("supply high flag missing");
  a_supply_autoclr: assert property (upd && !supply_high ##1 !upd ##1 rf |=> !reg_rdata[1])
    else $error("supply high flag not cleared");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 6'h30 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_dready_wins: assert property (dready_en |=> aux_oe[$past(dready_line)]
    && aux_out[$past(dready_line)] == $past(dready_level)) else $error("data-ready lost line");
  a_gpio_drives: assert property (!dready_en && gpio_oe[1] |=> aux_oe[1])
    else $error("general-purpose drive lost");
  a_alarm_on_upd: assert property ($rose(alarm1_active) |-> $past(upd, 2))
    else $error("alarm rose without update");
endmodule // smon_checker
bind smon_monitor smon_checker u_chk (.*);

// [smon_monitor_tb.sv]
`timescale 1ns/1ps
`include "smon_defs.vh"
module smon_monitor_tb;
  reg          clk = 0;
  reg          rst_n = 0;
  reg          upd = 0;
  reg  [175:0] raw_data = 0;
  reg  [175:0] filt_data = 0;
  reg  [11:0]  cond = 0;
  reg  [6:0]   aux_in = 0;
  wire [5:0]   reg_addr;
  wire         reg_wr;
  wire         reg_rd;
  wire [15:0]  reg_wdata;
  wire [15:0]  reg_rdata;
  wire [1:0]   aux_out;
  wire [1:0]   aux_oe;
  wire         alarm1_active;
  wire         alarm2_active;
  integer      seed = 32'h7624;
  integer      fails = 0;
  integer      total_checks = 0;
  integer      i;
  integer      j;
  reg  [15:0]  d, m, t1, t2, s;
  reg  [11:0]  c1, c2;
  reg  [5:0]   a;
  reg          e1, e2, p, l;
  always #50 clk = ~clk;
  smon_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  smon_monitor u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .upd(upd),
    .raw_data(raw_data), .filt_data(filt_data), .diag_fail(cond[11:6]),
    .selftest_err(cond[5]), .overrange(cond[4]), .serial_fail(cond[3]),
    .ctrl_upd_fail(cond[2]), .supply_high(cond[1]), .supply_low(cond[0]),
    .dready_en(aux_in[6]), .dready_line(aux_in[5]), .dready_level(aux_in[4]),
    .gpio_oe(aux_in[3:2]), .gpio_out(aux_in[1:0]), .aux_out(aux_out), .aux_oe(aux_oe),
    .alarm1_active(alarm1_active), .alarm2_active(alarm2_active));
  task chk(input [15:0] exp, input [15:0] got, input string name);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("BAD %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task pulse(input [11:0] c);
    begin
      @(posedge clk);
      cond <= c;
      upd <= 1'b1;
      @(posedge clk);
      upd <= 1'b0;
    end
  endtask
  function [15:0] flags(input [11:0] x, input [11:0] y);
    flags = {x[11:6] | y[11:6], 4'h0, x[5] | y[5], y[4], x[3:2] | y[3:2], y[1:0]};
  endfunction
  function cmp(input [15:0] t, input [15:0] v);
    cmp = t[15] ? $signed(v[13:0]) > $signed(t[13:0]) : $signed(v[13:0]) < $signed(t[13:0]);
  endfunction
  task final_report;
    begin
      if (fails == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #(100 * 20000);
    fails = fails + 1;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      a = 6'h26 + {i[4:0], 1'b0};
      m = i < 2 ? `SMON_THR_MASK : i < 4 ? `SMON_CNT_MASK : `SMON_CFG_MASK;
      u_host.rd(a, d);
      chk(16'h0000, d, "reset");
      t1 = 16'($random(seed));
      u_host.wr(a, t1);
      u_host.rd(a, d);
      chk(t1 & m, d, "rw");
    end
    u_host.wr(6'h2e, 16'h0000);
    u_host.wr(6'h3c, 16'hffff);
    u_host.rd(6'h3c, d);
    chk(16'h0000, d, "flag write");
    u_host.rd(6'h30, d);
    chk(16'h0000, d, "unmapped");
    for (i = 0; i < 10; i = i + 1) begin
      c1 = i == 0 ? 12'hfff : 12'($random(seed));
      c2 = 12'($random(seed));
      pulse(c1);
      pulse(c2);
      u_host.rd(6'h3c, d);
      chk(flags(c1, c2), d, "flags");
      u_host.rd(6'h3c, d);
      chk(16'h0000, d, "cleared");
      pulse(c2);
      u_host.rd(6'h3c, d);
      chk(flags(c2, c2), d, "reassert");
    end
    for (i = 1; i < 12; i = i + 1) begin
      @(posedge clk);
      for (j = 0; j < 11; j = j + 1) begin
        raw_data[j*16 +: 16] <= 16'($random(seed));
        filt_data[j*16 +: 16] <= 16'($random(seed));
      end
      {t1, t2} = $random(seed);
      {p, l} = 2'($random(seed));
      u_host.wr(6'h26, t1);
      u_host.wr(6'h28, t2);
      u_host.wr(6'h2e, {i[3:0], i[3:0], 3'b000, i[0], 2'b01, p, l});
      s = i[0] ? filt_data[(i-1)*16 +: 16] : raw_data[(i-1)*16 +: 16];
      e1 = cmp(t1, s);
      e2 = cmp(t2, s);
      pulse(12'h000);
      repeat (2) @(posedge clk);
      #1 chk({12'h000, e1, e2, ~((e1 | e2) ^ p), 1'b1},
        {12'h000, alarm1_active, alarm2_active, aux_out[l], aux_oe[l]}, "alarm");
      u_host.rd(6'h3c, d);
      pulse(12'h000);
      u_host.rd(6'h3c, d);
      chk({6'h00, e2, e1, 8'h00}, d, "alarm flags");
    end
    u_host.wr(6'h2a, 16'h0002);
    u_host.wr(6'h26, 16'h3ffb);
    u_host.wr(6'h2e, 16'h0146);
    for (i = 0; i < 7; i = i + 1) begin
      @(posedge clk);
      raw_data[15:0] <= 16'(10 * (i < 3 ? i : 4 - i));
      pulse(12'h000);
      if (i == 2 || i == 6) begin
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, i == 6}, {15'h0000, alarm1_active}, "rate");
      end
    end
    repeat (40) begin
      @(posedge clk);
      aux_in <= 7'($random(seed));
      @(posedge clk);
      #1 chk(aux_in[6] && aux_in[5] ? {14'h0000, 1'b1, aux_in[4]}
        : {14'h0000, aux_in[3], aux_in[1]}, {14'h0000, aux_oe[1], aux_out[1]}, "line two");
    end
    final_report;
  end
endmodule // smon_monitor_tb
